// ===== design/mirqs_defines.vh
`ifndef MIRQS_DEFINES_VH
`define MIRQS_DEFINES_VH

// ==========================================================================
// Register byte offsets on the APB.
`define MIRQS_OFF_RX_STATUS      8'h20
`define MIRQS_OFF_IRQ_STATUS     8'h24
`define MIRQS_OFF_IRQ_ENABLE_SET 8'h28
`define MIRQS_OFF_IRQ_ENABLE_CLR 8'h2C
`define MIRQS_OFF_IRQ_MASK_VIEW  8'h30

// ==========================================================================
// Receive status field positions.
`define MIRQS_RXS_FRAME_STORED   1
`define MIRQS_RXS_STORE_FAILED   2

// ==========================================================================
// Interrupt field positions, shared by status, enable, disable and mask.
`define MIRQS_IRQ_MGMT_DONE      0
`define MIRQS_IRQ_RX_DONE        1
`define MIRQS_IRQ_RX_USED        2
`define MIRQS_IRQ_TX_USED        3
`define MIRQS_IRQ_TX_UNDERRUN    4
`define MIRQS_IRQ_RETRY_LIMIT    5
`define MIRQS_IRQ_TX_EXHAUSTED   6
`define MIRQS_IRQ_TX_DONE        7
`define MIRQS_IRQ_RX_OVERRUN     10
`define MIRQS_IRQ_BUS_ERROR      11
`define MIRQS_IRQ_PAUSE_FRAME    12
`define MIRQS_IRQ_PAUSE_ZERO     13

// ==========================================================================
// Implemented bits and reset values.
`define MIRQS_IRQ_VALID          14'h3CFF
`define MIRQS_RXS_VALID          3'h6
`define MIRQS_RST_IRQ_STATUS     14'h0000
`define MIRQS_RST_IRQ_MASK       14'h3CFF
`define MIRQS_RST_RX_STATUS      3'h0

`endif

// ===== design/mirqs_top.v
// Function
// - Frame stored sets rx status; one written clears.
// - Store failure sets overrun; recover buffer; W1C.
// - Status bit 0: management done, read clears.
// - Status bit 1: frame stored, read clears.
// - Status bit 2: rx used bit seen.
// - Status bit 3: tx used bit seen.
// - Status bit 4: tx data late or error.
// - Bit 4 also: mid-frame used bit, queue write.
// - Status bit 5: retry limit exceeded, read clears.
// - Status bit 6: tx buffers exhausted mid-frame.
// - Status bit 7: frame transmitted, read clears.
// - Status bit 10: overrun status becoming set.
// - Status bit 11: DMA saw bus error.
// - Status bit 12: valid pause frame received.
// - Status bit 13: pause count reached zero.
// - Enable register ones unmask sources.
// - Disable register ones mask sources.
// - Mask view reads one per masked source.
`timescale 1ns/1ps
`include "mirqs_defines.vh"

module mirqs_top #(
   parameter ADDR_W = 8,
   parameter IRQ_W  = 14
) (
   // Clock and reset.
   input  wire              clk_i,
   input  wire              nrst_i,
   // APB slave.
   input  wire              psel_i,
   input  wire              penable_i,
   input  wire              pwrite_i,
   input  wire [ADDR_W-1:0] paddr_i,
   input  wire [31:0]       pwdata_i,
   output wire [31:0]       prdata_o,
   output wire              pready_o,
   output wire              pslverr_o,
   // Receive events, one-cycle pulses.
   input  wire              rx_done_i,
   input  wire              rx_store_failed_i,
   input  wire              rx_used_bit_seen_i,
   // Transmit events, one-cycle pulses.
   input  wire              tx_used_bit_seen_i,
   input  wire              tx_underrun_i,
   input  wire              tx_midframe_used_i,
   input  wire              tx_queue_ptr_wr_i,
   input  wire              retry_limit_hit_i,
   input  wire              tx_buffers_exhausted_i,
   input  wire              tx_done_i,
   // Bus, pause and management events, one-cycle pulses.
   input  wire              bus_error_i,
   input  wire              pause_frame_seen_i,
   input  wire              pause_count_zero_i,
   input  wire              mgmt_frame_done_i,
   // Status outputs.
   output wire              rx_frame_stored_o,
   output wire              rx_store_failed_o,
   output wire              buf_recover_o,
   output wire              irq_o
);

   // =======================================================================
   // Address decode helper.

   function sel_reg;
      input [ADDR_W-1:0] addr;
      input [7:0]        offset;
      begin
         sel_reg = (addr[7:0] == offset);
      end
   endfunction

   // =======================================================================
   // Reset synchroniser.

   reg rst_meta_ff;
   reg rst_sync_ff;

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   wire rst_n = rst_sync_ff;

   // =======================================================================
   // State registers.

   reg [IRQ_W-1:0] isr_ff;
   reg [IRQ_W-1:0] mask_ff;
   reg             rx_stored_ff;
   reg             rx_failed_ff;
   reg             recover_ff;
   reg             irq_ff;
   reg [31:0]      prdata_ff;
   reg             pready_ff;
   reg             pslverr_ff;

   // =======================================================================
   // APB phases. Setup is answered in the following access cycle.

   wire setup  = psel_i & ~penable_i;
   wire access = psel_i & penable_i & pready_ff;
   wire wr_acc = access & pwrite_i & ~pslverr_ff;
   wire rd_acc = access & ~pwrite_i & ~pslverr_ff;

   wire hit_rxs = sel_reg(paddr_i, `MIRQS_OFF_RX_STATUS);
   wire hit_isr = sel_reg(paddr_i, `MIRQS_OFF_IRQ_STATUS);
   wire hit_ier = sel_reg(paddr_i, `MIRQS_OFF_IRQ_ENABLE_SET);
   wire hit_idr = sel_reg(paddr_i, `MIRQS_OFF_IRQ_ENABLE_CLR);
   wire hit_imr = sel_reg(paddr_i, `MIRQS_OFF_IRQ_MASK_VIEW);
   wire hit_any = hit_rxs | hit_isr | hit_ier | hit_idr | hit_imr;

   // =======================================================================
   // Receive status bits, set by hardware and cleared by a written one.

   wire rxs_wr     = wr_acc & hit_rxs;
   wire clr_stored = rxs_wr & pwdata_i[`MIRQS_RXS_FRAME_STORED];
   wire clr_failed = rxs_wr & pwdata_i[`MIRQS_RXS_STORE_FAILED];

   // A new event in the cycle of the clear keeps the bit set.
   wire nxt_rx_stored = rx_done_i | (rx_stored_ff & ~clr_stored);
   wire nxt_rx_failed = rx_store_failed_i | (rx_failed_ff & ~clr_failed);

   // The overrun interrupt fires only on the status bit's rising edge.
   wire overrun_rise = nxt_rx_failed & ~rx_failed_ff;

   // =======================================================================
   // Interrupt event vector.

   reg [IRQ_W-1:0] ev;

   always @* begin
      ev                           = {IRQ_W{1'b0}};
      ev[`MIRQS_IRQ_MGMT_DONE]     = mgmt_frame_done_i;
      ev[`MIRQS_IRQ_RX_DONE]       = rx_done_i;
      ev[`MIRQS_IRQ_RX_USED]       = rx_used_bit_seen_i;
      ev[`MIRQS_IRQ_TX_USED]       = tx_used_bit_seen_i;
      ev[`MIRQS_IRQ_TX_UNDERRUN]   = tx_underrun_i
                                   | tx_midframe_used_i
                                   | tx_queue_ptr_wr_i;
      ev[`MIRQS_IRQ_RETRY_LIMIT]   = retry_limit_hit_i;
      ev[`MIRQS_IRQ_TX_EXHAUSTED]  = tx_buffers_exhausted_i;
      ev[`MIRQS_IRQ_TX_DONE]       = tx_done_i;
      ev[`MIRQS_IRQ_RX_OVERRUN]    = overrun_rise;
      ev[`MIRQS_IRQ_BUS_ERROR]     = bus_error_i;
      ev[`MIRQS_IRQ_PAUSE_FRAME]   = pause_frame_seen_i;
      ev[`MIRQS_IRQ_PAUSE_ZERO]    = pause_count_zero_i;
   end

   // =======================================================================
   // Per-bit status and mask logic.
   // A status read clears only the bits returned to software, so an event
   // landing between the setup and access cycles is never lost.

   wire [IRQ_W-1:0] valid   = `MIRQS_IRQ_VALID;
   wire             isr_rd  = rd_acc & hit_isr;
   wire             ier_wr  = wr_acc & hit_ier;
   wire             idr_wr  = wr_acc & hit_idr;
   wire [IRQ_W-1:0] nxt_isr;
   wire [IRQ_W-1:0] nxt_mask;

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_bit
         wire rd_clr = isr_rd & prdata_ff[gi];
         wire unmask = ier_wr & pwdata_i[gi];
         wire domask = idr_wr & pwdata_i[gi];
         // Set wins over the read clear.
         assign nxt_isr[gi]  = valid[gi] & (ev[gi] | (isr_ff[gi] & ~rd_clr));
         // Zero bits leave the mask as it is; a disable beats an enable.
         assign nxt_mask[gi] = valid[gi] & (domask | (mask_ff[gi] & ~unmask));
      end
   endgenerate

   // =======================================================================
   // Read data mux, sampled in the setup cycle.

   reg [31:0] rd_word;

   always @* begin
      rd_word = 32'h0000_0000;
      if (hit_rxs) begin
         rd_word[`MIRQS_RXS_FRAME_STORED] = rx_stored_ff;
         rd_word[`MIRQS_RXS_STORE_FAILED] = rx_failed_ff;
      end else if (hit_isr) begin
         rd_word[IRQ_W-1:0] = isr_ff;
      end else if (hit_imr) begin
         rd_word[IRQ_W-1:0] = mask_ff;
      end
   end

   // =======================================================================
   // Bus answer registers.

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff  <= pwrite_i ? 32'h0000_0000 : rd_word;
         pready_ff  <= 1'b1;
         pslverr_ff <= ~hit_any;
      end else begin
         // Any cycle that is not a setup drops the answer, so an abandoned
         // transfer cannot leave the ready flag standing.
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // =======================================================================
   // Block state.

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         isr_ff       <= `MIRQS_RST_IRQ_STATUS;
         mask_ff      <= `MIRQS_RST_IRQ_MASK;
         rx_stored_ff <= 1'b0;
         rx_failed_ff <= 1'b0;
         recover_ff   <= 1'b0;
         irq_ff       <= 1'b0;
      end else begin
         isr_ff       <= nxt_isr;
         mask_ff      <= nxt_mask;
         rx_stored_ff <= nxt_rx_stored;
         rx_failed_ff <= nxt_rx_failed;
         recover_ff   <= rx_store_failed_i;
         irq_ff       <= |(nxt_isr & ~nxt_mask);
      end
   end

   // =======================================================================
   // Outputs.

   assign prdata_o          = prdata_ff;
   assign pready_o          = pready_ff;
   assign pslverr_o         = pslverr_ff;
   assign rx_frame_stored_o = rx_stored_ff;
   assign rx_store_failed_o = rx_failed_ff;
   assign buf_recover_o     = recover_ff;
   assign irq_o             = irq_ff;

endmodule

// ===== bench/mirqs_monitor.sv
`timescale 1ns/1ps
module mirqs_monitor (
   // Clock, reset and APB.
   input wire        clk_i,
   input wire        nrst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   // Events and status outputs.
   input wire        rx_done_i,
   input wire        rx_store_failed_i,
   input wire        rx_frame_stored_o,
   input wire        buf_recover_o,
   input wire        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire mapped_w = paddr_i >= 8'h20 && paddr_i <= 8'h30 && paddr_i[1:0] == 2'b00;
   reg  en_seen_ff;
   reg  clr_ff;
   // =====================================
   // Remembers whether any source was ever unmasked and a pending frame-stored clear.
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_seen_ff <= 1'b0;
         clr_ff <= 1'b0;
      end else begin
         if (pready_o && pwrite_i && paddr_i == 8'h28 && |(pwdata_i[13:0] & 14'h3CFF)) en_seen_ff <= 1'b1;
         clr_ff <= pready_o && pwrite_i && paddr_i == 8'h20 && pwdata_i[1];
      end
   end
   pready_once_a: assert property (pready_o |=> !pready_o) else $error("pready held too long");
   pready_cause_a: assert property (pready_o |-> psel_i && penable_i && $past(psel_i) && !$past(penable_i))
      else $error("pready without setup");
   setup_answer_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no zero-wait answer");
   slverr_map_a: assert property (pready_o |-> pslverr_o == !mapped_w) else $error("bad error response");
   rdata_quiet_a: assert property (!pready_o || pwrite_i || pslverr_o |-> prdata_o == 32'h0) else $error("stray data");
   unused_zero_a: assert property (pready_o |-> prdata_o[31:14] == 18'h0 && prdata_o[9:8] == 2'h0)
      else $error("unused bits not zero");
   wo_read_a: assert property (pready_o && (paddr_i == 8'h28 || paddr_i == 8'h2C) |-> prdata_o == 32'h0)
      else $error("write-only register read back");
   recover_pulse_a: assert property (buf_recover_o == $past(rx_store_failed_i)) else $error("no recovery");
   stored_set_a: assert property (rx_done_i |-> ##[1:2] rx_frame_stored_o) else $error("frame not flagged");
   stored_clear_a: assert property ($fell(rx_frame_stored_o) |-> clr_ff || $past(clr_ff) || $past(clr_ff, 2))
      else $error("frame flag lost");
   irq_gate_a: assert property (irq_o |-> en_seen_ff) else $error("irq while all masked");
endmodule
bind mirqs_top mirqs_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .rx_done_i(rx_done_i), .rx_store_failed_i(rx_store_failed_i),
   .rx_frame_stored_o(rx_frame_stored_o), .buf_recover_o(buf_recover_o), .irq_o(irq_o));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg          clk_i = 1'b0;
   reg          nrst_i = 1'b0;
   reg          psel = 1'b0;
   reg          penable = 1'b0;
   reg          pwrite = 1'b0;
   reg  [7:0]   paddr = 8'h00;
   reg  [31:0]  pwdata = 32'h0;
   reg  [13:0]  ev = 14'h0;
   wire [31:0]  prdata;
   wire         pready, pslverr, stored, failed, irq;
   logic [32:0] q[$];
   int          mismatches = 0;
   int          n_tests = 0;
   int          b;
   reg  [13:0]  m;
   reg  [31:0]  r;
   always #20 clk_i = ~clk_i;
   mirqs_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .mgmt_frame_done_i(ev[0]), .rx_done_i(ev[1]), .rx_used_bit_seen_i(ev[2]), .tx_used_bit_seen_i(ev[3]),
      .tx_underrun_i(ev[4]), .retry_limit_hit_i(ev[5]), .tx_buffers_exhausted_i(ev[6]), .tx_done_i(ev[7]),
      .tx_midframe_used_i(ev[8]), .tx_queue_ptr_wr_i(ev[9]), .rx_store_failed_i(ev[10]), .bus_error_i(ev[11]),
      .pause_frame_seen_i(ev[12]), .pause_count_zero_i(ev[13]), .rx_frame_stored_o(stored),
      .rx_store_failed_o(failed), .buf_recover_o(), .irq_o(irq));
   // =====================================
   // Checking and verdict.
   task chk(input [32:0] got, input [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Every answer is compared with the oldest expected {error, data} note.
   always @(posedge clk_i) begin
      if (pready === 1'b1) begin
         if (q.size() == 0) chk(33'h0, 33'h1);
         else chk({pslverr, prdata}, q.pop_front());
      end
   end
   // =====================================
   // Bus and event drivers.
   task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
      int n;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      q.push_back(e);
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1);
      chk({1'b0, n}, 33'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input int i);
      @(posedge clk_i);
      ev[i] <= 1'b1;
      @(posedge clk_i);
      ev <= 14'h0;
      repeat (2) @(posedge clk_i);
   endtask
   // =====================================
   // Main sequence.
   initial begin
      r = $urandom(32'hB279BF98);
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({32'h0, irq}, 33'h0);
      apb(0, 8'h30, 0, {1'b0, 32'h3CFF});
      apb(0, 8'h24, 0, 33'h0);
      apb(0, 8'h28, 0, 33'h0);
      apb(0, 8'h2C, 0, 33'h0);
      apb(0, 8'h34, 0, {1'b1, 32'h0});
      apb(1, 8'h24, 32'hFFFFFFFF, 33'h0);
      r = $urandom;
      m = 14'h3CFF & ~r[13:0];
      apb(1, 8'h28, r, 33'h0);
      apb(0, 8'h30, 0, {19'h0, m});
      r = $urandom;
      m = m | (r[13:0] & 14'h3CFF);
      apb(1, 8'h2C, r, 33'h0);
      apb(0, 8'h30, 0, {19'h0, m});
      for (int i = 0; i < 14; i++) begin
         b = (i == 8 || i == 9) ? 4 : i;
         pulse(i);
         chk({32'h0, irq}, {32'h0, ~m[b]});
         chk({31'h0, failed, stored}, {31'h0, i == 10, i == 1});
         apb(0, 8'h24, 0, {1'b0, 32'h1 << b});
         apb(0, 8'h24, 0, 33'h0);
         apb(0, 8'h20, 0, {30'h0, i == 10, i == 1, 1'b0});
         apb(1, 8'h20, 32'h6, 33'h0);
         chk({32'h0, irq}, 33'h0);
      end
      pulse(10);
      apb(0, 8'h24, 0, {1'b0, 32'h400});
      pulse(10);
      apb(0, 8'h24, 0, 33'h0);
      apb(1, 8'h20, 32'h6, 33'h0);
      @(posedge clk_i);
      chk({1'b0, q.size()}, 33'h0);
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      give_verdict;
   end
endmodule
